// ---- qsv_host_model.sv ----
// Purpose: host side: kicks the watchdog and pulls up open-drain lines
// Assumes: kick gap well inside the watchdog period
// Notes:   released lines read high through the board pull-ups
`timescale 1ns/100ps
// ------------------------------------------------------------
// host model
// ------------------------------------------------------------
module qsv_host_model #(
	parameter int unsigned KICK_GAP = 40 // cycles between trigger edges
) (
	input  wire logic       clk_i,     // core clock
	input  wire logic       kick_en_i, // software alive
	input  wire logic [4:0] oe_n_i,    // pin enables, low pulls down
	input  wire logic [4:0] val_i,     // pin values
	output logic            kick_o,    // trigger line
	output logic [4:0]      line_o     // board levels
);
	int unsigned gap_q  = 0;    // cycles since last edge
	logic        kick_q = 1'b0; // trigger level, one driver only
	assign kick_o = kick_q;
	// pull-ups on released lines
	assign line_o = oe_n_i | val_i;
	always @(posedge clk_i) begin
		if (kick_en_i && gap_q == KICK_GAP - 1) begin
			kick_q <= ~kick_q;
			gap_q <= 0;
		end else if (kick_en_i) begin
			gap_q <= gap_q + 1;
		end
	end
endmodule : qsv_host_model

// ---- qsv_pkg.sv ----
// Purpose: shared constants and the per-channel release-delay counter.
// Assumes: 100 MHz core clock; all timing is built on a 100 us tick.
// Notes:   delays are counted in whole ticks; register map offsets are byte addresses.

// ----------------------------------------------------------------
// package
// ----------------------------------------------------------------
package qsv_pkg;
	// clock and tick timing
	localparam int unsigned CLK_PERIOD_NS   = 10;       // core clock period
	localparam int unsigned TICK_NS         = 100_000;  // delay tick, 100 us
	localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
	// watchdog nominal timeout
	localparam int unsigned WDOG_TIMEOUT_MS = 610;
	localparam int unsigned WDOG_TICKS      = (WDOG_TIMEOUT_MS * 1_000_000) / TICK_NS;
	// programmable delay range, 1.4 ms to 10 s
	localparam int unsigned DELAY_MIN_US    = 1400;
	localparam int unsigned DELAY_MAX_S     = 10;
	localparam int unsigned DELAY_MIN_TICKS = (DELAY_MIN_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int unsigned DELAY_MAX_TICKS =
		int'((64'(DELAY_MAX_S) * 64'd1_000_000_000) / 64'(TICK_NS));
	localparam int unsigned DELAY_W         = 17;       // holds DELAY_MAX_TICKS
	// fixed release delay used when the select pin reads low
	localparam int unsigned FIXED_DELAY_TICKS = 200;
	// channel count and event layout
	localparam int unsigned NUM_CHAN        = 4;
	localparam int unsigned EVT_W           = 5;        // 4 channel events + watchdog
	localparam int unsigned EVT_WDOG        = 4;        // bit of the watchdog event
	// register map (byte addresses)
	localparam logic [7:0]  ADDR_STATUS     = 8'h00;    // sticky events, read only
	localparam logic [7:0]  ADDR_CLEAR      = 8'h04;    // write one to clear
	localparam logic [7:0]  ADDR_ENABLE     = 8'h08;    // interrupt enables
	localparam logic [7:0]  ADDR_STATE      = 8'h0c;    // live output state
	localparam logic [7:0]  ADDR_DELAY0     = 8'h10;    // channel 1 delay, +4 per channel
	localparam logic [7:0]  ADDR_STRIDE     = 8'h04;
	// reset values
	localparam logic [DELAY_W-1:0] DELAY_RST = 17'h0_00c8;  // 200 ticks
	localparam logic [EVT_W-1:0]   ENABLE_RST = 5'h00;
	// watchdog states, one hot
	typedef enum logic [2:0] {
		QSV_WD_STOP    = 3'b001,
		QSV_WD_RUN     = 3'b010,
		QSV_WD_EXPIRED = 3'b100
	} qsv_wd_state_t;
endpackage : qsv_pkg

`timescale 1ns/100ps

// ----------------------------------------------------------------
// release-delay counter for one channel
// ----------------------------------------------------------------
module qsv_chan_delay #(
	parameter int unsigned DW = qsv_pkg::DELAY_W
) (
	input  wire logic          clk_i,        // core clock
	input  wire logic          reset_i,      // synchronous, active high
	input  wire logic          tick_i,       // one-cycle tick enable
	input  wire logic          fault_i,      // reset condition present
	input  wire logic [DW-1:0] delay_ticks_i, // delay to apply on release
	output logic               hold_o        // high while reset asserted
);
	import qsv_pkg::*;

	// a one-bit counter cannot count out any useful delay
	if (DW < 2) begin : g_chk_dw
		$error("delay counter too narrow");
	end

	logic [DW-1:0] cnt_q;                    // ticks spent releasing
	logic          hold_q;                   // reset asserted
	wire  [DW-1:0] cnt_inc = cnt_q + 1'b1;   // next tick count
	wire           done    = (cnt_inc >= delay_ticks_i);

	// hold while faulted, then count out the delay
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hold_q <= 1'b1;                  // asserted from power-up
			cnt_q  <= '0;
		end else if (fault_i) begin
			hold_q <= 1'b1;
			cnt_q  <= '0;
		end else if (hold_q && tick_i) begin
			if (done) begin
				hold_q <= 1'b0;
			end else begin
				cnt_q  <= cnt_inc;
			end
		end
	end

	assign hold_o = hold_q;
endmodule : qsv_chan_delay

// ---- qsv_supervisor.sv ----
// Purpose: four-channel supply supervisor core with watchdog.
// Assumes: monitor inputs are comparator levels from another domain.
// Notes:   open-drain pins are value plus active-low enable; value is always 0.

`timescale 1ns/100ps

// Contract
// - manual reset low asserts channel one
// - rails one to three below threshold assert
// - rail four low side asserts channel four
// - rail four high side asserts channel four
// - reset outputs open-drain, pulled low only
// - release only after the channel delay (the free-running tick lets a release come up to one tick early)
// - select pin low uses fixed delay
// - select pin high uses programmable delay
// - either kick edge restarts watchdog period
// - watchdog starts on channel one release
// - timeout pulls watchdog output low
// - no timeout leaves watchdog output released
// - delay settable 1.4 ms to 10 s
module qsv_supervisor #(
	parameter int unsigned TICK_CYCLES       = qsv_pkg::TICK_CYCLES,
	parameter int unsigned WDOG_TICKS        = qsv_pkg::WDOG_TICKS,
	parameter int unsigned FIXED_DELAY_TICKS = qsv_pkg::FIXED_DELAY_TICKS
) (
	input  wire logic        clk_i,                 // core clock
	input  wire logic        reset_i,               // synchronous, active high
	input  wire logic [7:0]  reg_addr_i,            // register byte address
	input  wire logic [31:0] reg_wdata_i,           // write data
	input  wire logic        reg_wr_i,              // write strobe
	input  wire logic        reg_rd_i,              // read strobe
	output logic      [31:0] reg_rdata_o,           // read data, next cycle
	input  wire logic        manual_reset_n_i,      // manual reset, active low
	input  wire logic        rail1_monitor_in_i,    // high: rail 1 below threshold
	input  wire logic        rail2_monitor_in_i,    // high: rail 2 below threshold
	input  wire logic        rail3_monitor_in_i,    // high: rail 3 below threshold
	input  wire logic        rail4_low_side_in_i,   // high: rail 4 below low threshold
	input  wire logic        rail4_high_side_in_i,  // high: rail 4 above high threshold
	input  wire logic [3:0]  chan_delay_select_i,   // high: programmable delay
	input  wire logic        wdog_kick_in_i,        // watchdog trigger
	output logic             chan1_reset_out_n_o,   // pin value, always low
	output logic             chan1_reset_oe_n_o,    // low while pulling down
	output logic             chan2_reset_out_n_o,
	output logic             chan2_reset_oe_n_o,
	output logic             chan3_reset_out_n_o,
	output logic             chan3_reset_oe_n_o,
	output logic             chan4_reset_out_n_o,
	output logic             chan4_reset_oe_n_o,
	output logic             wdog_timeout_out_n_o,  // pin value, always low
	output logic             wdog_timeout_oe_n_o,   // low while timed out
	output logic             irq_o                  // level interrupt
);
	import qsv_pkg::*;

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
	localparam int unsigned WD_W  = $clog2(WDOG_TICKS + 1);

	if (TICK_CYCLES < 2) begin : g_chk_tick
		$error("tick divider must be at least 2");
	end
	if (WDOG_TICKS < 1) begin : g_chk_wdog
		$error("watchdog period must be at least one tick");
	end
	if (FIXED_DELAY_TICKS < 1 || FIXED_DELAY_TICKS > DELAY_MAX_TICKS) begin : g_chk_fix
		$error("fixed delay outside counter range");
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int unsigned NSYNC = 11;
	wire  [NSYNC-1:0] async_in = {wdog_kick_in_i, chan_delay_select_i,
		rail4_high_side_in_i, rail4_low_side_in_i, rail3_monitor_in_i,
		rail2_monitor_in_i, rail1_monitor_in_i, manual_reset_n_i};
	logic [NSYNC-1:0] meta_q;                 // first stage, read by sync_q only
	logic [NSYNC-1:0] sync_q;                 // second stage, safe to use
	logic             kick_prev_q;            // previous synced kick level

	// two flops on every pin input
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_q      <= '0;
			sync_q      <= '0;
			kick_prev_q <= 1'b0;
		end else begin
			meta_q      <= async_in;
			sync_q      <= meta_q;
			kick_prev_q <= sync_q[10];
		end
	end

	wire       mr_n_s   = sync_q[0];          // manual reset, synced
	wire [2:0] rail_s   = sync_q[3:1];        // rails 1..3 below threshold
	wire       r4_low_s = sync_q[4];
	wire       r4_hi_s  = sync_q[5];
	wire [3:0] sel_s    = sync_q[9:6];        // delay select per channel
	wire       kick     = sync_q[10] ^ kick_prev_q;

	// ----------------------------------------------------------------
	// tick divider
	// ----------------------------------------------------------------
	logic [PRE_W-1:0] pre_q;                  // cycles within a tick
	logic             tick_q;                 // one-cycle tick enable
	wire              pre_end = (pre_q == PRE_W'(TICK_CYCLES - 1));

	// free-running prescaler; a delay may end up to one tick early
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pre_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q  <= pre_end ? '0 : pre_q + 1'b1;
			tick_q <= pre_end;
		end
	end

	// ----------------------------------------------------------------
	// reset conditions and channel delays
	// ----------------------------------------------------------------
	logic [3:0]         fault;                // per-channel reset condition
	logic [3:0]         hold;                 // per-channel reset asserted
	logic [DELAY_W-1:0] delay_q [NUM_CHAN];   // programmable delays

	assign fault[0] = ~mr_n_s | rail_s[0];
	assign fault[2:1] = rail_s[2:1];
	assign fault[3] = r4_low_s | r4_hi_s;

	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		logic [DELAY_W-1:0] prog;             // clamped programmable delay
		logic [DELAY_W-1:0] use_delay;        // delay actually applied
		assign prog = (delay_q[c] < DELAY_W'(DELAY_MIN_TICKS)) ? DELAY_W'(DELAY_MIN_TICKS) :
			(delay_q[c] > DELAY_W'(DELAY_MAX_TICKS)) ? DELAY_W'(DELAY_MAX_TICKS) : delay_q[c];
		assign use_delay = sel_s[c] ? prog : DELAY_W'(FIXED_DELAY_TICKS);

		qsv_chan_delay #(
			.DW            (DELAY_W)
		) u_delay (
			.clk_i         (clk_i),
			.reset_i       (reset_i),
			.tick_i        (tick_q),
			.fault_i       (fault[c]),
			.delay_ticks_i (use_delay),
			.hold_o        (hold[c])
		);
	end

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	qsv_wd_state_t   wd_state_q;              // watchdog state
	qsv_wd_state_t   wd_state_d;
	logic [WD_W-1:0] wd_cnt_q;                // ticks since last kick
	logic [WD_W-1:0] wd_cnt_d;
	wire  [WD_W-1:0] wd_inc  = wd_cnt_q + 1'b1;
	wire             wd_done = tick_q && (wd_inc >= WD_W'(WDOG_TICKS));

	// next state for the watchdog
	always_comb begin
		wd_state_d = wd_state_q;
		wd_cnt_d   = wd_cnt_q;
		case (wd_state_q)
			QSV_WD_STOP: begin
				wd_cnt_d = '0;
				if (!hold[0]) begin
					wd_state_d = QSV_WD_RUN;
				end
			end
			QSV_WD_RUN: begin
				if (kick) begin
					wd_cnt_d = '0;
				end else if (wd_done) begin
					wd_state_d = QSV_WD_EXPIRED;
					wd_cnt_d   = '0;
				end else if (tick_q) begin
					wd_cnt_d = wd_inc;
				end
			end
			QSV_WD_EXPIRED: begin
				// a fresh kick releases the timeout and restarts timing
				if (kick) begin
					wd_state_d = QSV_WD_RUN;
				end
			end
			default: begin
				wd_state_d = QSV_WD_STOP;
				wd_cnt_d   = '0;
			end
		endcase
		if (hold[0]) begin
			wd_state_d = QSV_WD_STOP;
			wd_cnt_d   = '0;
		end
	end

	// watchdog registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wd_state_q <= QSV_WD_STOP;
			wd_cnt_q   <= '0;
		end else begin
			wd_state_q <= wd_state_d;
			wd_cnt_q   <= wd_cnt_d;
		end
	end

	wire wd_expired = (wd_state_q == QSV_WD_EXPIRED);
	wire wd_fire    = (wd_state_d == QSV_WD_EXPIRED) && !wd_expired;

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic [3:0] rst_oe_n_q;                   // per-channel enables
	logic       wd_oe_n_q;
	logic       pin_low_q;                    // constant low drive value

	// open-drain drive: enable low pulls the pin down
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rst_oe_n_q <= 4'h0;               // resets pulled low in reset
			wd_oe_n_q  <= 1'b1;
			pin_low_q  <= 1'b0;
		end else begin
			rst_oe_n_q <= ~hold;
			wd_oe_n_q  <= ~wd_expired;
			pin_low_q  <= 1'b0;
		end
	end

	assign chan1_reset_out_n_o  = pin_low_q;
	assign chan2_reset_out_n_o  = pin_low_q;
	assign chan3_reset_out_n_o  = pin_low_q;
	assign chan4_reset_out_n_o  = pin_low_q;
	assign wdog_timeout_out_n_o = pin_low_q;
	assign chan1_reset_oe_n_o   = rst_oe_n_q[0];
	assign chan2_reset_oe_n_o   = rst_oe_n_q[1];
	assign chan3_reset_oe_n_o   = rst_oe_n_q[2];
	assign chan4_reset_oe_n_o   = rst_oe_n_q[3];
	assign wdog_timeout_oe_n_o  = wd_oe_n_q;

	// ----------------------------------------------------------------
	// registers and interrupt
	// ----------------------------------------------------------------
	logic [3:0]       hold_prev_q;            // for assertion edges
	logic [EVT_W-1:0] status_q;               // sticky events
	logic [EVT_W-1:0] enable_q;               // interrupt enables
	logic             irq_q;
	logic [31:0]      rdata_q;

	wire [EVT_W-1:0] events = {wd_fire, hold & ~hold_prev_q};
	wire             wr_clear = reg_wr_i && (reg_addr_i == ADDR_CLEAR);
	wire             wr_en    = reg_wr_i && (reg_addr_i == ADDR_ENABLE);
	// set wins over a clear in the same cycle
	wire [EVT_W-1:0] status_d =
		(status_q & ~(wr_clear ? reg_wdata_i[EVT_W-1:0] : '0)) | events;

	logic [31:0] rd_mux;                      // read selection
	always_comb begin
		rd_mux = 32'h0000_0000;               // unmapped reads as zero
		if (reg_addr_i == ADDR_STATUS) begin
			rd_mux = 32'(status_q);
		end else if (reg_addr_i == ADDR_ENABLE) begin
			rd_mux = 32'(enable_q);
		end else if (reg_addr_i == ADDR_STATE) begin
			rd_mux = 32'({wd_expired, hold});
		end
		for (int c = 0; c < NUM_CHAN; c++) begin
			if (reg_addr_i == ADDR_DELAY0 + 8'(c) * ADDR_STRIDE) begin
				rd_mux = 32'(delay_q[c]);
			end
		end
	end

	// register writes, status and read data
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hold_prev_q <= 4'hf;
			status_q    <= '0;
			enable_q    <= ENABLE_RST;
			irq_q       <= 1'b0;
			rdata_q     <= 32'h0000_0000;
			for (int c = 0; c < NUM_CHAN; c++) begin
				delay_q[c] <= DELAY_RST;
			end
		end else begin
			hold_prev_q <= hold;
			status_q    <= status_d;
			irq_q       <= |(status_d & enable_q);
			rdata_q     <= reg_rd_i ? rd_mux : 32'h0000_0000;
			if (wr_en) begin
				enable_q <= reg_wdata_i[EVT_W-1:0];
			end
			for (int c = 0; c < NUM_CHAN; c++) begin
				if (reg_wr_i && reg_addr_i == ADDR_DELAY0 + 8'(c) * ADDR_STRIDE) begin
					delay_q[c] <= reg_wdata_i[DELAY_W-1:0];
				end
			end
		end
	end

	assign irq_o       = irq_q;
	assign reg_rdata_o = rdata_q;
endmodule : qsv_supervisor

// ---- qsv_supervisor_sva.sv ----
// Purpose: port-level checks of the supervisor core
// Assumes: one clock; reset_i synchronous and active high
// Notes:   two saturating counters give the timing checks exact figures
`timescale 1ns/100ps
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module qsv_supervisor_chk #(
	parameter int unsigned TICK_CYCLES       = 4,  // cycles per tick
	parameter int unsigned WDOG_TICKS        = 20, // watchdog period, ticks
	parameter int unsigned FIXED_DELAY_TICKS = 3   // fixed release delay, ticks
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic manual_reset_n_i,
	input wire logic rail2_monitor_in_i,
	input wire logic rail4_low_side_in_i,
	input wire logic rail4_high_side_in_i,
	input wire logic wdog_kick_in_i,
	input wire logic chan1_reset_out_n_o,
	input wire logic chan1_reset_oe_n_o,
	input wire logic chan2_reset_out_n_o,
	input wire logic chan2_reset_oe_n_o,
	input wire logic chan3_reset_out_n_o,
	input wire logic chan4_reset_out_n_o,
	input wire logic chan4_reset_oe_n_o,
	input wire logic wdog_timeout_out_n_o,
	input wire logic wdog_timeout_oe_n_o
);
	localparam int unsigned REL_MIN = (FIXED_DELAY_TICKS - 1) * TICK_CYCLES; // earliest release
	localparam int unsigned WD_MIN  = (WDOG_TICKS - 1) * TICK_CYCLES;        // earliest timeout
	localparam int unsigned WD_MAX  = (WDOG_TICKS + 1) * TICK_CYCLES + 8;    // sync slack added
	logic [15:0] quiet_q; // cycles since rail 2 last faulted
	logic [15:0] idle_q;  // cycles since kick edge or channel 1 release
	logic        kick_q;  // previous trigger level
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// counters saturate so a long quiet spell never wraps
	always_ff @(posedge clk_i) begin
		kick_q <= wdog_kick_in_i;
		if (reset_i || rail2_monitor_in_i) begin
			quiet_q <= 16'h0000;
		end else if (quiet_q != 16'hffff) begin
			quiet_q <= quiet_q + 16'h0001;
		end
		if (reset_i || !chan1_reset_oe_n_o || kick_q != wdog_kick_in_i) begin
			idle_q <= 16'h0000;
		end else if (idle_q != 16'hffff) begin
			idle_q <= idle_q + 16'h0001;
		end
	end
	mr_hold_a: assert property ((!manual_reset_n_i) [*6] |-> !chan1_reset_oe_n_o)
		else $error("channel 1 not held by manual reset");
	rail_hold_a: assert property (rail2_monitor_in_i [*6] |-> !chan2_reset_oe_n_o)
		else $error("channel 2 not held by low rail");
	low_side_a: assert property (rail4_low_side_in_i [*6] |-> !chan4_reset_oe_n_o)
		else $error("channel 4 not held by low side");
	high_side_a: assert property (rail4_high_side_in_i [*6] |-> !chan4_reset_oe_n_o)
		else $error("channel 4 not held by high side");
	pin_value_a: assert property (!(chan1_reset_out_n_o | chan2_reset_out_n_o | chan3_reset_out_n_o
		| chan4_reset_out_n_o | wdog_timeout_out_n_o))
		else $error("open drain pin drives high");
	early_free_a: assert property ($rose(chan2_reset_oe_n_o) |-> quiet_q >= REL_MIN)
		else $error("channel 2 released before its delay");
	wd_stop_a: assert property (!chan1_reset_oe_n_o [*2] |-> wdog_timeout_oe_n_o)
		else $error("watchdog output low while channel 1 held");
	wd_early_a: assert property ($fell(wdog_timeout_oe_n_o) |-> idle_q >= WD_MIN)
		else $error("watchdog timed out early");
	wd_late_a: assert property (idle_q == 16'(WD_MAX) |-> !wdog_timeout_oe_n_o)
		else $error("watchdog timeout missing");
endmodule : qsv_supervisor_chk

// ---- qsv_supervisor_tb_top.sv ----
// Purpose: self-checking bench for the supervisor core
// Assumes: short tick and watchdog parameters keep the run brief
// Notes:   pins are judged on the pulled-up lines of the host model
`timescale 1ns/100ps
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module qsv_supervisor_tb_top;
	import qsv_pkg::*;
	localparam int CH [6] = '{0, 0, 1, 2, 3, 3}; // channel hit by each fault source
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [5:0]  flt = 6'h00;                 // fault sources, bit 0 manual
	logic [3:0]  chan_delay_select_i = 4'h0;  // all fixed at first
	logic        kick_en = 1'b1;              // host alive
	logic        wdog_kick_in_i;
	logic [4:0]  oe_n, val, line;             // watchdog, channels 4..1
	logic        irq_o;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cyc = 0;
	wire manual_reset_n_i = ~flt[0];
	wire rail1_monitor_in_i = flt[1];
	wire rail2_monitor_in_i = flt[2];
	wire rail3_monitor_in_i = flt[3];
	wire rail4_low_side_in_i = flt[4];
	wire rail4_high_side_in_i = flt[5];
	qsv_supervisor #(.TICK_CYCLES(4), .WDOG_TICKS(20), .FIXED_DELAY_TICKS(3)) DUT (
		.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.manual_reset_n_i, .rail1_monitor_in_i, .rail2_monitor_in_i, .rail3_monitor_in_i,
		.rail4_low_side_in_i, .rail4_high_side_in_i, .chan_delay_select_i, .wdog_kick_in_i,
		.chan1_reset_out_n_o(val[0]), .chan1_reset_oe_n_o(oe_n[0]),
		.chan2_reset_out_n_o(val[1]), .chan2_reset_oe_n_o(oe_n[1]),
		.chan3_reset_out_n_o(val[2]), .chan3_reset_oe_n_o(oe_n[2]),
		.chan4_reset_out_n_o(val[3]), .chan4_reset_oe_n_o(oe_n[3]),
		.wdog_timeout_out_n_o(val[4]), .wdog_timeout_oe_n_o(oe_n[4]), .irq_o);
	qsv_host_model #(.KICK_GAP(40)) u_host (.clk_i, .kick_en_i(kick_en), .oe_n_i(oe_n),
		.val_i(val), .kick_o(wdog_kick_in_i), .line_o(line));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	// settle one ns past the edge before looking
	task automatic cw(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cw
	task automatic setf(input logic [5:0] f);
		@(posedge clk_i);
		flt <= f;
	endtask : setf
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("rdata", reg_rdata_o, exp);
	endtask : rd
	// clear faults; line still low at lo, free by hi
	task automatic rel(input int c, input int lo, input int hi);
		setf(6'h00);
		cw(lo);
		chk("held", 32'(line[c]), 32'h0000_0000);
		cw(hi - lo);
		chk("freed", 32'(line[c]), 32'h0000_0001);
	endtask : rel
	task automatic t_fixed;
		for (int s = 0; s < 6; s++) begin
			setf(6'(1 << s));
			cw(8);
			chk("asserted", 32'(line[CH[s]]), 32'h0000_0000);
			rel(CH[s], 8, 20);
		end
	endtask : t_fixed
	task automatic t_prog;
		@(posedge clk_i);
		chan_delay_select_i <= 4'h4;
		wr(ADDR_DELAY0 + 8'h08, 32'h0000_0014);
		rd(ADDR_DELAY0 + 8'h08, 32'h0000_0014);
		setf(6'h08);
		cw(8);
		setf(6'h00);
		cw(40);
		setf(6'h08);
		cw(4);
		rel(2, 70, 90);
		wr(ADDR_DELAY0 + 8'h08, 32'h0000_0005);
		setf(6'h08);
		cw(8);
		rel(2, 48, 66);
	endtask : t_prog
	task automatic t_irq;
		wr(ADDR_ENABLE, 32'h0000_0002);
		wr(ADDR_CLEAR, 32'h0000_001f);
		rd(ADDR_STATUS, 32'h0000_0000);
		setf(6'h04);
		cw(8);
		chk("irq", 32'(irq_o), 32'h0000_0001);
		rd(ADDR_STATUS, 32'h0000_0002);
		rd(ADDR_STATE, 32'h0000_0002);
		cw(1);
		chk("rdata_idle", reg_rdata_o, 32'h0000_0000);
		wr(ADDR_STATUS, 32'h0000_001f);
		wr(ADDR_ENABLE, 32'h0000_0000);
		cw(2);
		chk("irq", 32'(irq_o), 32'h0000_0000);
		wr(ADDR_CLEAR, 32'h0000_0002);
		rd(ADDR_STATUS, 32'h0000_0000);
		rd(ADDR_CLEAR, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		rel(1, 8, 20);
	endtask : t_irq
	task automatic t_wdog;
		@(posedge clk_i);
		kick_en <= 1'b0;
		cw(140);
		chk("wdog", 32'(line[4]), 32'h0000_0000);
		rd(ADDR_STATUS, 32'h0000_0010);
		rd(ADDR_STATE, 32'h0000_0010);
		@(posedge clk_i);
		kick_en <= 1'b1;
		cw(50);
		chk("wdog", 32'(line[4]), 32'h0000_0001);
		@(posedge clk_i);
		kick_en <= 1'b0;
		setf(6'h01);
		cw(150);
		chk("wdog", 32'(line[4]), 32'h0000_0001);
		rel(0, 8, 20);
		cw(60);
		chk("wdog", 32'(line[4]), 32'h0000_0001);
		cw(40);
		chk("wdog", 32'(line[4]), 32'h0000_0000);
	endtask : t_wdog
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// hang guard, run needs about 1000 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(ADDR_ENABLE, 32'(ENABLE_RST));
		rd(ADDR_DELAY0, 32'(DELAY_RST));
		cw(30);
		chk("released", 32'(line[3:0]), 32'h0000_000f);
		t_fixed();
		t_prog();
		t_irq();
		t_wdog();
		end_of_test();
	end
endmodule : qsv_supervisor_tb_top
bind qsv_supervisor qsv_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES), .WDOG_TICKS(WDOG_TICKS),
	.FIXED_DELAY_TICKS(FIXED_DELAY_TICKS)) u_chk (.clk_i, .reset_i, .manual_reset_n_i,
	.rail2_monitor_in_i, .rail4_low_side_in_i, .rail4_high_side_in_i, .wdog_kick_in_i,
	.chan1_reset_out_n_o, .chan1_reset_oe_n_o, .chan2_reset_out_n_o, .chan2_reset_oe_n_o,
	.chan3_reset_out_n_o, .chan4_reset_out_n_o, .chan4_reset_oe_n_o, .wdog_timeout_out_n_o,
	.wdog_timeout_oe_n_o);
